// ==== core/cbn_exec.sv ====
// execution unit for the bit-clear and branch-on-minus instructions
`timescale 1ns/1ns
// How it works
// - clear_register_bit_op (pattern 1001) zeroes the selected bit and keeps the other bits.
// - with area-select 0 the 8-bit address lands in the fast access area, not the bank.
// - with area-select 1 the address is bank_select_reg joined with the 8-bit field.
// - area-select 0 with extended set enabled and field at most 5Fh uses indexed offset.
// - branch_on_minus_op (1110 0110, 8-bit offset) branches only when negative is 1.
// - a taken branch loads next-instruction address plus twice the signed offset.
// - a taken branch costs two instruction cycles, the second empty; untaken costs one.
module cbn_exec (
    // clock and reset
    input  wire logic                     aclk,
    input  wire logic                     aresetn,
    // instruction issue from the fetch stage
    input  wire logic                     instr_valid,
    input  wire logic [15:0]              instr_word,
    output logic                          instr_ready,
    // core context
    input  wire logic [cbn_pkg::PC_W-1:0] pc_next,
    input  wire logic                     neg_flag,
    input  wire logic [11:0]              index_base,
    // program counter load
    output logic                          pc_load,
    output logic [cbn_pkg::PC_W-1:0]      pc_target,
    // file register port
    output logic [11:0]                   fr_addr,
    output logic                          fr_rd_en,
    input  wire logic [7:0]               fr_rdata,
    output logic                          fr_wr_en,
    output logic [7:0]                    fr_wdata,
    // axi4-lite slave
    input  wire logic [3:0]               s_awaddr,
    input  wire logic                     s_awvalid,
    output logic                          s_awready,
    input  wire logic [31:0]              s_wdata,
    input  wire logic [3:0]               s_wstrb,
    input  wire logic                     s_wvalid,
    output logic                          s_wready,
    output logic [1:0]                    s_bresp,
    output logic                          s_bvalid,
    input  wire logic                     s_bready,
    input  wire logic [3:0]               s_araddr,
    input  wire logic                     s_arvalid,
    output logic                          s_arready,
    output logic [31:0]                   s_rdata,
    output logic [1:0]                    s_rresp,
    output logic                          s_rvalid,
    input  wire logic                     s_rready
);
    // ----------------------------------------------------------------
    // address resolution
    // ----------------------------------------------------------------
    // fast area is split after 5Fh: fields up to 5Fh map to bank 0, the rest to the top bank
    function automatic logic [11:0] resolve_addr(input logic a, input logic [7:0] f,
            input logic ext, input logic [3:0] bank, input logic [11:0] base);
        if (a)
            resolve_addr = {bank, f};
        else if (ext && f <= cbn_pkg::INDEX_LIMIT)
            resolve_addr = base + {4'h0, f};
        else if (f <= cbn_pkg::INDEX_LIMIT)
            resolve_addr = {cbn_pkg::FAST_LOW_BANK, f};
        else
            resolve_addr = {cbn_pkg::FAST_HIGH_BANK, f};
    endfunction
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    cbn_pkg::cbn_phase_t       ph_ff, nxt_ph;
    cbn_pkg::cbn_op_t          op_ff, nxt_op;
    logic                      flush_ff, nxt_flush;
    logic [2:0]                bit_ff, nxt_bit;
    logic [11:0]               addr_ff, nxt_addr;
    logic [7:0]                rd_ff, nxt_rd;
    logic [7:0]                wd_ff, nxt_wd;
    logic                      rd_en_ff, nxt_rd_en;
    logic                      wr_en_ff, nxt_wr_en;
    logic                      load_ff, nxt_load;
    logic                      taken_ff, nxt_taken;
    logic [cbn_pkg::PC_W-1:0]  tgt_ff, nxt_tgt;
    logic [cbn_pkg::PC_W-1:0]  exp_tgt;
    logic [31:0]               ctrl_ff, nxt_ctrl;
    logic [31:0]               count_ff, nxt_count;
    logic                      accept;
    logic                      ext_en;
    logic [3:0]                bank_sel;
    assign ext_en      = ctrl_ff[cbn_pkg::CTRL_EXT_BIT];
    assign bank_sel    = ctrl_ff[cbn_pkg::CTRL_BANK_LSB +: 4];
    // the empty cycle after a taken branch refuses new work
    assign instr_ready = (ph_ff == cbn_pkg::PH_Q1) && !flush_ff;
    assign accept      = instr_ready && instr_valid;
    // next address plus twice the sign-extended offset
    assign exp_tgt     = pc_next + {{(cbn_pkg::PC_W-9){instr_word[7]}}, instr_word[7:0], 1'b0};
    assign pc_load   = load_ff;
    assign pc_target = tgt_ff;
    assign fr_addr   = addr_ff;
    assign fr_rd_en  = rd_en_ff;
    assign fr_wr_en  = wr_en_ff;
    assign fr_wdata  = wd_ff;
    // ----------------------------------------------------------------
    // execution sequencing
    // ----------------------------------------------------------------
    // one aclk per phase; flags are never written by this unit
    always_comb
    begin
        nxt_ph    = ph_ff;
        nxt_op    = op_ff;
        nxt_flush = flush_ff;
        nxt_bit   = bit_ff;
        nxt_addr  = addr_ff;
        nxt_rd    = rd_ff;
        nxt_wd    = wd_ff;
        nxt_rd_en = 1'b0;
        nxt_wr_en = 1'b0;
        nxt_load  = 1'b0;
        nxt_taken = taken_ff;
        nxt_tgt   = tgt_ff;
        nxt_count = count_ff;
        unique case (ph_ff)
            cbn_pkg::PH_Q1:
            begin
                nxt_ph = cbn_pkg::PH_Q2;
                nxt_op = cbn_pkg::OP_NONE;
                if (accept && instr_word[15:12] == cbn_pkg::CLR_BIT_PAT)
                begin
                    nxt_op    = cbn_pkg::OP_CLR;
                    nxt_bit   = instr_word[11:9];
                    nxt_addr  = resolve_addr(instr_word[8], instr_word[7:0], ext_en,
                                             bank_sel, index_base);
                    nxt_rd_en = 1'b1;
                end
                else if (accept && instr_word[15:8] == cbn_pkg::BR_MINUS_PAT)
                begin
                    nxt_op  = cbn_pkg::OP_BRN;
                    nxt_tgt = exp_tgt;
                end
            end
            cbn_pkg::PH_Q2:
            begin
                nxt_ph = cbn_pkg::PH_Q3;
                if (op_ff == cbn_pkg::OP_CLR)
                    nxt_rd = fr_rdata;
            end
            cbn_pkg::PH_Q3:
            begin
                nxt_ph = cbn_pkg::PH_Q4;
                if (op_ff == cbn_pkg::OP_CLR)
                begin
                    nxt_wd    = rd_ff & ~(8'h01 << bit_ff);
                    nxt_wr_en = 1'b1;
                end
                if (op_ff == cbn_pkg::OP_BRN)
                begin
                    nxt_taken = neg_flag;
                    nxt_load  = neg_flag;
                end
            end
            cbn_pkg::PH_Q4:
            begin
                nxt_ph    = cbn_pkg::PH_Q1;
                // a taken branch turns the next cycle into an empty one
                nxt_flush = (op_ff == cbn_pkg::OP_BRN) && load_ff;
                if (op_ff != cbn_pkg::OP_NONE)
                    nxt_count = count_ff + 32'h0000_0001;
            end
        endcase
    end
    // registering of the execution state
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ph_ff    <= cbn_pkg::PH_Q1;
            op_ff    <= cbn_pkg::OP_NONE;
            flush_ff <= 1'b0;
            bit_ff   <= 3'h0;
            addr_ff  <= 12'h000;
            rd_ff    <= 8'h00;
            wd_ff    <= 8'h00;
            rd_en_ff <= 1'b0;
            wr_en_ff <= 1'b0;
            load_ff  <= 1'b0;
            taken_ff <= 1'b0;
            tgt_ff   <= '0;
            count_ff <= 32'h0000_0000;
        end
        else
        begin
            ph_ff    <= nxt_ph;
            op_ff    <= nxt_op;
            flush_ff <= nxt_flush;
            bit_ff   <= nxt_bit;
            addr_ff  <= nxt_addr;
            rd_ff    <= nxt_rd;
            wd_ff    <= nxt_wd;
            rd_en_ff <= nxt_rd_en;
            wr_en_ff <= nxt_wr_en;
            load_ff  <= nxt_load;
            taken_ff <= nxt_taken;
            tgt_ff   <= nxt_tgt;
            count_ff <= nxt_count;
        end
    end
    // ----------------------------------------------------------------
    // axi4-lite register slave
    // ----------------------------------------------------------------
    logic        bvalid_ff, nxt_bvalid;
    logic [1:0]  bresp_ff, nxt_bresp;
    logic        rvalid_ff, nxt_rvalid;
    logic [1:0]  rresp_ff, nxt_rresp;
    logic [31:0] rdata_ff, nxt_rdata;
    logic        wr_go;
    logic        rd_go;
    // address and data are taken together, so arrival order does not matter
    assign s_awready = s_awvalid && s_wvalid && !bvalid_ff;
    assign s_wready  = s_awready;
    assign s_arready = !rvalid_ff;
    assign wr_go     = s_awready;
    assign rd_go     = s_arvalid && s_arready;
    assign s_bvalid  = bvalid_ff;
    assign s_bresp   = bresp_ff;
    assign s_rvalid  = rvalid_ff;
    assign s_rresp   = rresp_ff;
    assign s_rdata   = rdata_ff;
    // only the control word is writable; others answer with an error
    always_comb
    begin
        nxt_ctrl   = ctrl_ff;
        nxt_bvalid = bvalid_ff && !s_bready;
        nxt_bresp  = bresp_ff;
        nxt_rvalid = rvalid_ff && !s_rready;
        nxt_rresp  = rresp_ff;
        nxt_rdata  = rdata_ff;
        if (wr_go)
        begin
            nxt_bvalid = 1'b1;
            nxt_bresp  = cbn_pkg::RESP_SLVERR;
            if (s_awaddr == cbn_pkg::CTRL_OFFS)
            begin
                nxt_bresp = cbn_pkg::RESP_OKAY;
                for (int i = 0; i < 4; i++)
                    if (s_wstrb[i])
                        nxt_ctrl[i*8 +: 8] = s_wdata[i*8 +: 8];
                nxt_ctrl[31:12] = 20'h00000;
                nxt_ctrl[7:1]   = 7'h00;
            end
        end
        if (rd_go)
        begin
            nxt_rvalid = 1'b1;
            nxt_rresp  = cbn_pkg::RESP_OKAY;
            unique case (s_araddr)
                cbn_pkg::CTRL_OFFS:  nxt_rdata = ctrl_ff;
                cbn_pkg::STAT_OFFS:  nxt_rdata = {28'h0000000, ph_ff, taken_ff, flush_ff};
                cbn_pkg::COUNT_OFFS: nxt_rdata = count_ff;
                default:
                begin
                    nxt_rdata = 32'h0000_0000;
                    nxt_rresp = cbn_pkg::RESP_SLVERR;
                end
            endcase
        end
    end
    // registering of the bus side
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_ff   <= cbn_pkg::CTRL_RST;
            bvalid_ff <= 1'b0;
            bresp_ff  <= cbn_pkg::RESP_OKAY;
            rvalid_ff <= 1'b0;
            rresp_ff  <= cbn_pkg::RESP_OKAY;
            rdata_ff  <= 32'h0000_0000;
        end
        else
        begin
            ctrl_ff   <= nxt_ctrl;
            bvalid_ff <= nxt_bvalid;
            bresp_ff  <= nxt_bresp;
            rvalid_ff <= nxt_rvalid;
            rresp_ff  <= nxt_rresp;
            rdata_ff  <= nxt_rdata;
        end
    end
    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire logic clr_acc = accept && instr_word[15:12] == cbn_pkg::CLR_BIT_PAT;
    wire logic brn_acc = accept && instr_word[15:8] == cbn_pkg::BR_MINUS_PAT;
    property p_clear_bit;
        clr_acc ##3 1'b1 |-> fr_wr_en &&
            fr_wdata == ($past(fr_rdata, 2) & ~(8'h01 << $past(instr_word[11:9], 3)));
    endproperty
    a_clear_bit: assert property (p_clear_bit) else $error("bit clear value wrong");
    // the split point decides the bank, so check the whole address
    property p_fast_area;
        clr_acc && !instr_word[8] && !(ext_en && instr_word[7:0] <= 8'h5f)
            |=> fr_addr == {(($past(instr_word[7:0]) <= 8'h5f) ? 4'h0 : 4'hf),
                $past(instr_word[7:0])};
    endproperty
    a_fast_area: assert property (p_fast_area) else $error("fast area address wrong");
    property p_bank_addr;
        clr_acc && instr_word[8] |=> fr_addr == {$past(bank_sel), $past(instr_word[7:0])};
    endproperty
    a_bank_addr: assert property (p_bank_addr) else $error("banked address wrong");
    property p_indexed;
        clr_acc && !instr_word[8] && ext_en && instr_word[7:0] <= 8'h5f
            |=> fr_addr == $past(index_base) + {4'h0, $past(instr_word[7:0])};
    endproperty
    a_indexed: assert property (p_indexed) else $error("indexed address wrong");
    property p_take_on_neg;
        brn_acc ##2 1'b1 |=> pc_load == $past(neg_flag);
    endproperty
    a_take_on_neg: assert property (p_take_on_neg) else $error("branch decision wrong");
    property p_target;
        brn_acc ##3 pc_load |-> pc_target == $past(pc_next, 3)
            + {{(cbn_pkg::PC_W-9){$past(instr_word[7], 3)}}, $past(instr_word[7:0], 3), 1'b0};
    endproperty
    a_target: assert property (p_target) else $error("branch target wrong");
    property p_empty_cycle;
        pc_load |=> (!instr_ready)[*4] ##1 instr_ready;
    endproperty
    a_empty_cycle: assert property (p_empty_cycle) else $error("no empty cycle");
    property p_no_jump_one;
        brn_acc ##3 !pc_load |=> instr_ready;
    endproperty
    a_no_jump_one: assert property (p_no_jump_one) else $error("untaken too long");
    property p_rmw;
        fr_wr_en |-> ph_ff == cbn_pkg::PH_Q4 && $past(fr_rd_en, 2) && !pc_load;
    endproperty
    a_rmw: assert property (p_rmw) else $error("write without read");
    c_clear:  cover property (clr_acc ##3 fr_wr_en);
    c_taken:  cover property (brn_acc ##3 pc_load);
    c_untake: cover property (brn_acc ##3 !pc_load);
    c_index:  cover property (clr_acc && !instr_word[8] && ext_en);
endmodule // cbn_exec

// ==== pkg/cbn_pkg.sv ====
// constants and types shared by the bit-clear and branch-on-minus execution unit
package cbn_pkg;
    // ----------------------------------------------------------------
    // register map (byte addresses) and reset values
    // ----------------------------------------------------------------
    localparam logic [3:0]  CTRL_OFFS      = 4'h0;
    localparam logic [3:0]  STAT_OFFS      = 4'h4;
    localparam logic [3:0]  COUNT_OFFS     = 4'h8;
    localparam logic [31:0] CTRL_RST       = 32'h0000_0000;
    localparam int          CTRL_EXT_BIT   = 0;
    localparam int          CTRL_BANK_LSB  = 8;
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;
    // ----------------------------------------------------------------
    // instruction encodings and addressing constants
    // ----------------------------------------------------------------
    localparam logic [3:0]  CLR_BIT_PAT    = 4'h9;
    localparam logic [7:0]  BR_MINUS_PAT   = 8'he6;
    localparam logic [7:0]  INDEX_LIMIT    = 8'h5f;
    localparam logic [3:0]  FAST_LOW_BANK  = 4'h0;
    localparam logic [3:0]  FAST_HIGH_BANK = 4'hf;
    localparam int          PC_W           = 21;
    // ----------------------------------------------------------------
    // clock phases inside one instruction cycle, gray coded
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        PH_Q1 = 2'b00,
        PH_Q2 = 2'b01,
        PH_Q3 = 2'b11,
        PH_Q4 = 2'b10
    } cbn_phase_t;
    typedef enum logic [1:0] {
        OP_NONE = 2'b00,
        OP_CLR  = 2'b01,
        OP_BRN  = 2'b11
    } cbn_op_t;
endpackage

// ==== tb/cbn_exec_tb.sv ====
// self-checking bench for the bit-clear and branch-on-minus execution unit
`timescale 1ns/1ns
module cbn_exec_tb;
    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic                     aclk;
    logic                     aresetn;
    logic                     instr_valid;
    logic [15:0]              instr_word;
    logic                     instr_ready;
    logic [cbn_pkg::PC_W-1:0] pc_next;
    logic                     neg_flag;
    logic [11:0]              index_base;
    logic                     pc_load;
    logic [cbn_pkg::PC_W-1:0] pc_target;
    logic [11:0]              fr_addr;
    logic                     fr_rd_en;
    logic [7:0]               fr_rdata;
    logic                     fr_wr_en;
    logic [7:0]               fr_wdata;
    logic [3:0]               s_awaddr;
    logic                     s_awvalid;
    logic                     s_awready;
    logic [31:0]              s_wdata;
    logic [3:0]               s_wstrb;
    logic                     s_wvalid;
    logic                     s_wready;
    logic [1:0]               s_bresp;
    logic                     s_bvalid;
    logic                     s_bready;
    logic [3:0]               s_araddr;
    logic                     s_arvalid;
    logic                     s_arready;
    logic [31:0]              s_rdata;
    logic [1:0]               s_rresp;
    logic                     s_rvalid;
    logic                     s_rready;
    int                       error_cnt;
    int                       n_checks;
    int                       exp_count;
    logic                     ext_q;
    logic [3:0]               bank_q;

    cbn_exec DUT (.aclk(aclk), .aresetn(aresetn), .instr_valid(instr_valid),
        .instr_word(instr_word), .instr_ready(instr_ready), .pc_next(pc_next),
        .neg_flag(neg_flag), .index_base(index_base), .pc_load(pc_load),
        .pc_target(pc_target), .fr_addr(fr_addr), .fr_rd_en(fr_rd_en), .fr_rdata(fr_rdata),
        .fr_wr_en(fr_wr_en), .fr_wdata(fr_wdata), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
        .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
        .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
        .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
        .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready));

    // ----------------------------------------------------------------
    // checking helpers
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up();
        if (error_cnt == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // resolved file address for a clear-bit, from area bit, field and bank setup
    function automatic logic [11:0] exp_addr(input logic a, input logic [7:0] f,
                                             input logic [11:0] base);
        if (a)
            return {bank_q, f};
        if (ext_q && f <= cbn_pkg::INDEX_LIMIT)
            return base + {4'h0, f};
        return (f <= cbn_pkg::INDEX_LIMIT) ? {cbn_pkg::FAST_LOW_BANK, f}
                                           : {cbn_pkg::FAST_HIGH_BANK, f};
    endfunction

    // branch target: next address plus twice the signed offset, wrapped to the counter width
    function automatic logic [cbn_pkg::PC_W-1:0] exp_target(
            input logic [cbn_pkg::PC_W-1:0] pcn, input logic [7:0] n);
        return pcn + {{(cbn_pkg::PC_W-9){n[7]}}, n, 1'b0};
    endfunction

    // ----------------------------------------------------------------
    // axi4-lite master
    // ----------------------------------------------------------------
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] st,
                          input logic [1:0] er);
        s_awaddr  <= a;
        s_wdata   <= d;
        s_wstrb   <= st;
        s_awvalid <= 1'b1;
        s_wvalid  <= 1'b1;
        s_bready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_awvalid && s_awready)
                s_awvalid <= 1'b0;
            if (s_wvalid && s_wready)
                s_wvalid <= 1'b0;
        end while (s_bvalid !== 1'b1);
        s_bready <= 1'b0;
        check("bresp", s_bresp, er);
        // idle edge, so a following call never lowers and raises bready in one step
        @(posedge aclk);
    endtask

    task automatic axi_rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
        s_araddr  <= a;
        s_arvalid <= 1'b1;
        s_rready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_arvalid && s_arready)
                s_arvalid <= 1'b0;
        end while (s_rvalid !== 1'b1);
        s_rready <= 1'b0;
        check("rresp", s_rresp, er);
        check("rdata", s_rdata, ed);
        // idle edge, so a following call never lowers and raises rready in one step
        @(posedge aclk);
    endtask

    task automatic set_ctrl(input logic ext, input logic [3:0] bank);
        ext_q  = ext;
        bank_q = bank;
        axi_wr(cbn_pkg::CTRL_OFFS, {20'h0, bank, 7'h0, ext}, 4'hf, cbn_pkg::RESP_OKAY);
        axi_rd(cbn_pkg::CTRL_OFFS, {20'h0, bank, 7'h0, ext}, cbn_pkg::RESP_OKAY);
    endtask

    // ----------------------------------------------------------------
    // one instruction, checked phase by phase
    // ----------------------------------------------------------------
    task automatic issue(input logic [15:0] w, input logic [20:0] pcn, input logic neg,
                         input logic [11:0] base, input logic [7:0] rd);
        logic clr;
        logic brn;
        logic take;
        clr  = (w[15:12] == cbn_pkg::CLR_BIT_PAT);
        brn  = (w[15:8] == cbn_pkg::BR_MINUS_PAT);
        take = brn && neg;
        instr_word  <= w;
        pc_next     <= pcn;
        neg_flag    <= neg;
        index_base  <= base;
        fr_rdata    <= rd;
        instr_valid <= 1'b1;
        @(posedge aclk);
        while (instr_ready !== 1'b1)
            @(posedge aclk);
        instr_valid <= 1'b0;
        @(posedge aclk);
        fr_rdata <= ~rd; // read data is only promised in the read phase
        check("fr_rd_en", fr_rd_en, clr);
        if (clr)
            check("fr_addr", fr_addr, exp_addr(w[8], w[7:0], base));
        @(posedge aclk);
        check("fr_wr_early", fr_wr_en, 1'b0);
        @(posedge aclk);
        check("fr_wr_en", fr_wr_en, clr);
        if (clr)
            check("fr_wdata", fr_wdata, rd & ~(8'h01 << w[11:9]));
        check("pc_load", pc_load, take);
        if (take)
            check("pc_target", pc_target, exp_target(pcn, w[7:0]));
        if (clr || brn)
            exp_count++;
        if (take)
        begin
            for (int i = 0; i < 4; i++)
            begin
                @(posedge aclk);
                check("empty_ready", instr_ready, 1'b0);
            end
        end
        // the next decode slot must open right after the checked cycles
        @(posedge aclk);
        check("next_ready", instr_ready, 1'b1);
    endtask

    // ----------------------------------------------------------------
    // clock, watchdog and main sequence
    // ----------------------------------------------------------------
    initial
    begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    // the whole run needs well under 2000 cycles
    initial
    begin
        repeat (20000) @(posedge aclk);
        error_cnt++;
        wrap_up();
    end

    initial
    begin
        logic [31:0] rv;
        logic [15:0] w;
        aresetn = 1'b0;
        {instr_valid, instr_word, pc_next, neg_flag, index_base, fr_rdata} = '0;
        {s_awaddr, s_awvalid, s_wdata, s_wstrb, s_wvalid, s_bready} = '0;
        {s_araddr, s_arvalid, s_rready} = '0;
        error_cnt = 0;
        n_checks  = 0;
        exp_count = 0;
        ext_q     = 1'b0;
        bank_q    = 4'h0;
        void'($urandom(32'h7680));
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(cbn_pkg::CTRL_OFFS, cbn_pkg::CTRL_RST, cbn_pkg::RESP_OKAY);
        axi_rd(4'hc, 32'h0, cbn_pkg::RESP_SLVERR);
        axi_wr(cbn_pkg::STAT_OFFS, 32'h1, 4'hf, cbn_pkg::RESP_SLVERR);
        axi_wr(4'hc, 32'hffff_ffff, 4'hf, cbn_pkg::RESP_SLVERR);
        axi_rd(cbn_pkg::CTRL_OFFS, cbn_pkg::CTRL_RST, cbn_pkg::RESP_OKAY);
        // byte strobes: the low byte is masked, so extended mode stays off
        axi_wr(cbn_pkg::CTRL_OFFS, 32'h0000_0f01, 4'he, cbn_pkg::RESP_OKAY);
        axi_rd(cbn_pkg::CTRL_OFFS, 32'h0000_0f00, cbn_pkg::RESP_OKAY);
        // corners: both sides of the fast-area split, bank path, index wrap
        set_ctrl(1'b0, 4'h3);
        issue(16'h9e10, 21'h0, 1'b0, 12'h0, 8'hc7);
        issue(16'h9060, 21'h0, 1'b0, 12'h0, 8'hff);
        issue(16'h975f, 21'h0, 1'b0, 12'h0, 8'h5a);
        set_ctrl(1'b1, 4'ha);
        issue(16'h9a5f, 21'h0, 1'b0, 12'hff0, 8'hff);
        issue(16'h9a60, 21'h0, 1'b0, 12'hff0, 8'hff);
        // branch offsets at both ends, address wrap, untaken and foreign codes
        issue(16'he680, 21'h000100, 1'b1, 12'h0, 8'h0);
        issue(16'he67f, 21'h1ffffe, 1'b1, 12'h0, 8'h0);
        issue(16'he605, 21'h000100, 1'b0, 12'h0, 8'h0);
        issue(16'he705, 21'h000100, 1'b1, 12'h0, 8'h0);
        issue(16'h8123, 21'h000100, 1'b1, 12'h0, 8'h0);
        for (int i = 0; i < 80; i++)
        begin
            rv = $urandom;
            w  = rv[15:0];
            case (rv[17:16])
                2'd0:    w[15:12] = cbn_pkg::CLR_BIT_PAT;
                2'd1:    w[15:8] = cbn_pkg::BR_MINUS_PAT;
                default: w[15:12] = {1'b0, rv[20:18]};
            endcase
            if (rv[31:29] == 3'h0)
                set_ctrl(rv[28], rv[27:24]);
            rv = $urandom;
            issue(w, rv[20:0], rv[21], {rv[31:24], rv[3:0]}, rv[29:22]);
        end
        axi_rd(cbn_pkg::COUNT_OFFS, 32'(exp_count), cbn_pkg::RESP_OKAY);
        wrap_up();
    end
endmodule // cbn_exec_tb
